/* logic/tcsc_cfg.svh */
// Constants for the tunable capacitor serial controller.
// Assumes a 40 MHz core clock; included by bare name.
`ifndef TCSC_CFG_SVH
`define TCSC_CFG_SVH

// ==========================================
// Register map (Avalon word addresses as byte offsets)
`define TCSC_OFF_CTRL      4'h0
`define TCSC_OFF_WORD      4'h4
`define TCSC_OFF_STATUS    4'h8
`define TCSC_OFF_LAST      4'hc

// ==========================================
// Control word fields, word width and device count
`define TCSC_STB_BIT       5
`define TCSC_CAP_MSB       4
`define TCSC_WORD_BITS     8
`define TCSC_NUM_DEV       4

// ==========================================
// Reset values
`define TCSC_WORD_RST      8'h00
`define TCSC_SEL_RST       2'h0

// ==========================================
// Timing
`define TCSC_CLK_MHZ       40
`define TCSC_HALF_CYC      8'h04
`define TCSC_SWITCH_US     12
`define TCSC_WAKE_US       70
`define TCSC_SWITCH_CYC    (`TCSC_SWITCH_US * `TCSC_CLK_MHZ)
`define TCSC_WAKE_CYC      (`TCSC_WAKE_US * `TCSC_CLK_MHZ)

`endif

/* logic/tcsc_pkg.sv */
// Types for the tunable capacitor serial controller.
// Assumes nothing beyond the config header.
`default_nettype none
package tcsc_pkg;
  typedef enum logic [4:0]
  {
    TCSC_IDLE  = 5'b00001,
    TCSC_SETUP = 5'b00010,
    TCSC_LOW   = 5'b00100,
    TCSC_HIGH  = 5'b01000,
    TCSC_HOLD  = 5'b10000
  } tcsc_state_t;
endpackage
`default_nettype wire

/* logic/tcsc_settle.sv */
// Settle timer: counts down the capacitor switching or wake-up wait.
// Assumes start is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
`default_nettype none
module tcsc_settle
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [12:0] load,
  output logic             busy
);
  logic [12:0] count;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      count <= 13'h0000;
    else if (start)
      count <= load;
    else if (count != 13'h0000)
      count <= count - 13'h0001;
  end

  assign busy = (count != 13'h0000);
endmodule
`default_nettype wire

/* logic/tcsc_ctrl.sv */
// Serial master for up to four tunable capacitors sharing clock and data.
// Assumes Avalon-MM software access on core_clk; pins go straight to the devices.
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tcsc_cfg.svh"
module tcsc_ctrl
  import tcsc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             serial_clk,
  output logic             serial_data,
  output logic [3:0]       serial_latch_enable
);
  tcsc_state_t state;
  logic [7:0]  shift;
  logic [2:0]  bit_cnt;
  logic [7:0]  half_cnt;
  logic [1:0]  dev_sel;
  logic [7:0]  last_word [0:3];
  logic [4:0]  last_cap;
  logic        last_stb;
  logic        settle_start;
  logic [12:0] settle_load;
  logic        settle_busy;
  logic        go;
  logic        half_done;
  logic [7:0]  word_in;
  logic        rd_pending;
  logic [7:0]  word_hold;
  logic [1:0]  frame_dev;
  logic        frame_idle;
  logic [3:0]  pulse_cnt;
  logic        clk_prev;

  // ==========================================
  // Avalon slave
  // Writes to the word register while busy stall until the frame ends.
  // Enable must sit low between frames, so also wait for the pin to drop
  assign frame_idle = (state == TCSC_IDLE) && (serial_latch_enable == 4'h0);
  assign go = avs_write && (avs_address == `TCSC_OFF_WORD) && frame_idle;
  assign avs_waitrequest = (avs_read && !rd_pending) ||
    (avs_write && (avs_address == `TCSC_OFF_WORD) && !frame_idle);
  // Reserved bits forced to zero whatever software writes
  assign word_in = {2'b00, avs_writedata[`TCSC_STB_BIT:0]};

  always_ff @(posedge core_clk)
  begin
    if (rst)
      rd_pending <= 1'b0;
    else
      rd_pending <= avs_read && !rd_pending;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !rd_pending)
    begin
      case (avs_address)
        `TCSC_OFF_CTRL:   avs_readdata <= {30'h0, dev_sel};
        `TCSC_OFF_STATUS: avs_readdata <= {30'h0, settle_busy, state != TCSC_IDLE};
        `TCSC_OFF_LAST:   avs_readdata <= {24'h00_0000, last_word[dev_sel]};
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      dev_sel <= `TCSC_SEL_RST;
    else if (avs_write && (avs_address == `TCSC_OFF_CTRL))
      dev_sel <= avs_writedata[1:0];
  end

  // ==========================================
  // Serial engine
  assign half_done = (half_cnt == `TCSC_HALF_CYC);

  always_ff @(posedge core_clk)
  begin
    if (rst || go || half_done || state == TCSC_IDLE)
      half_cnt <= 8'h00;
    else
      half_cnt <= half_cnt + 8'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state     <= TCSC_IDLE;
      shift     <= `TCSC_WORD_RST;
      bit_cnt   <= 3'h0;
      word_hold <= `TCSC_WORD_RST;
      frame_dev <= `TCSC_SEL_RST;
    end
    else
    begin
      case (state)
        TCSC_IDLE:
          if (go)
          begin
            shift     <= word_in;
            word_hold <= word_in;
            frame_dev <= dev_sel;
            bit_cnt   <= 3'h7;
            state     <= TCSC_SETUP;
          end
        TCSC_SETUP:
          if (half_done)
            state <= TCSC_HIGH;
        TCSC_HIGH:
          if (half_done)
          begin
            // Next bit leaves as the clock falls, far from the rising edge
            if (bit_cnt != 3'h0)
              shift <= {shift[6:0], 1'b0};
            state <= TCSC_LOW;
          end
        TCSC_LOW:
          if (half_done)
          begin
            if (bit_cnt == 3'h0)
              state <= TCSC_HOLD;
            else
            begin
              bit_cnt <= bit_cnt - 3'h1;
              state   <= TCSC_HIGH;
            end
          end
        TCSC_HOLD:
          if (half_done)
            state <= TCSC_IDLE;
        default:
          state <= TCSC_IDLE;
      endcase
    end
  end

  // Clock idles low, so the device sees nothing outside a frame
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      serial_clk          <= 1'b0;
      serial_data         <= 1'b0;
      serial_latch_enable <= 4'h0;
    end
    else
    begin
      serial_clk  <= (state == TCSC_HIGH);
      serial_data <= (state == TCSC_IDLE) ? 1'b0 : shift[7];
      serial_latch_enable <= (state == TCSC_IDLE) ? 4'h0 : (4'h1 << frame_dev);
    end
  end

  // ==========================================
  // Settle tracking
  assign settle_start = (state == TCSC_HOLD) && half_done;
  // Wake-up dominates; plain switch otherwise
  assign settle_load = (last_stb && !word_hold[`TCSC_STB_BIT]) ? 13'(`TCSC_WAKE_CYC) :
                       13'(`TCSC_SWITCH_CYC);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      last_word[0] <= `TCSC_WORD_RST;
      last_word[1] <= `TCSC_WORD_RST;
      last_word[2] <= `TCSC_WORD_RST;
      last_word[3] <= `TCSC_WORD_RST;
    end
    else if (settle_start)
      last_word[frame_dev] <= word_hold;
  end

  assign last_stb = last_word[frame_dev][`TCSC_STB_BIT];
  assign last_cap = last_word[frame_dev][`TCSC_CAP_MSB:0];

  tcsc_settle u_settle
  (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (settle_start),
    .load     (settle_load),
    .busy     (settle_busy)
  );

  // ==========================================
  // Checks
  sequence s_frame_start;
    $rose(|serial_latch_enable);
  endsequence

  // Pulses counted on the pin itself, not on the state machine
  always_ff @(posedge core_clk)
  begin
    clk_prev <= serial_clk;
    if (rst || go)
      pulse_cnt <= 4'h0;
    else if (serial_clk && !clk_prev)
      pulse_cnt <= pulse_cnt + 4'h1;
  end

  property p_eight_pulses;
    @(posedge core_clk) disable iff (rst)
      $fell(|serial_latch_enable) |-> (pulse_cnt == 4'h8);
  endproperty
  a_eight_pulses: assert property (p_eight_pulses) else $error("clock pulse count wrong");

  property p_enable_first;
    @(posedge core_clk) disable iff (rst)
      s_frame_start |-> !serial_clk;
  endproperty
  a_enable_first: assert property (p_enable_first) else $error("clock high at enable rise");

  property p_data_stable;
    @(posedge core_clk) disable iff (rst)
      serial_clk |-> $stable(serial_data);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved while clock high");

  property p_onehot_enable;
    @(posedge core_clk) disable iff (rst)
      $onehot0(serial_latch_enable);
  endproperty
  a_onehot_enable: assert property (p_onehot_enable) else $error("two enables high");

  property p_no_clk_idle;
    @(posedge core_clk) disable iff (rst)
      (serial_latch_enable == 4'h0) |-> !serial_clk;
  endproperty
  a_no_clk_idle: assert property (p_no_clk_idle) else $error("clock outside frame");

  property p_reserved_zero;
    @(posedge core_clk) disable iff (rst)
      go |=> (shift[7:6] == 2'b00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_eight_clocks;
    @(posedge core_clk) disable iff (rst)
      go |-> ##[1:100] (state == TCSC_HOLD);
  endproperty
  a_eight_clocks: assert property (p_eight_clocks) else $error("frame too long");

  property p_settle_after_latch;
    @(posedge core_clk) disable iff (rst)
      settle_start |=> ##1 settle_busy;
  endproperty
  a_settle_after_latch: assert property (p_settle_after_latch) else $error("no settle");

  property p_frame_ends_low;
    @(posedge core_clk) disable iff (rst)
      $fell(|serial_latch_enable) |-> !serial_clk && $past(state == TCSC_HOLD, 2);
  endproperty
  a_frame_ends_low: assert property (p_frame_ends_low) else $error("bad latch edge");

  property p_wake_long;
    @(posedge core_clk) disable iff (rst)
      (settle_start && last_stb && !word_hold[`TCSC_STB_BIT]) |=> settle_busy [*8];
  endproperty
  a_wake_long: assert property (p_wake_long) else $error("wake wait short");

  property p_cap_kept;
    @(posedge core_clk) disable iff (rst)
      settle_start |=> (last_cap == $past(word_hold[`TCSC_CAP_MSB:0]));
  endproperty
  a_cap_kept: assert property (p_cap_kept) else $error("cap state lost");
endmodule
`default_nettype wire

/* sim/tcsc_dev_model.sv */
// Behavioural tunable capacitor seen from its three serial pins.
// Assumes the controller drives clock, data and this device's enable.
`timescale 1ns/1ps
`default_nettype none
module tcsc_dev_model
(
  input  wire logic  serial_clk,
  input  wire logic  serial_data,
  input  wire logic  serial_latch_enable,
  output logic [4:0] cap_state,
  output logic       standby_select,
  output logic [7:0] word_seen,
  output int         fault_cnt
);
  logic [7:0] shift_q;
  initial
  begin
    shift_q = 8'h00;
    cap_state = 5'h00;
    standby_select = 1'b0;
    word_seen = 8'h00;
    fault_cnt = 0;
  end
  // No bit counter: only the last eight survive
  always @(posedge serial_clk)
    if (serial_latch_enable)
      shift_q <= {shift_q[6:0], serial_data};
  always @(negedge serial_latch_enable)
  begin
    word_seen <= shift_q;
    standby_select <= shift_q[5];
    cap_state <= shift_q[4:0];
    if (shift_q[7:6] != 2'h0)
      fault_cnt++;
  end
  always @(posedge serial_latch_enable)
    if (serial_clk)
      fault_cnt++;
  always @(serial_data)
    if (serial_clk && serial_latch_enable)
      fault_cnt++;
endmodule
`default_nettype wire

/* sim/tunable_cap_serial_control_test.sv */
// Bench for the tunable capacitor serial controller.
// Assumes four device models sharing the serial clock and data lines.
`timescale 1ns/1ps
`default_nettype none
module tunable_cap_serial_control_test;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        serial_clk;
  logic        serial_data;
  logic [3:0]  serial_latch_enable;
  logic [4:0]  cap [4];
  logic        stb [4];
  logic [7:0]  seen [4];
  int          fcnt [4];
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc = 0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  tcsc_ctrl dut
  (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_clk(serial_clk), .serial_data(serial_data),
    .serial_latch_enable(serial_latch_enable)
  );
  for (genvar i = 0; i < 4; i++)
  begin : g_dev
    tcsc_dev_model u_dev
    (
      .serial_clk(serial_clk), .serial_data(serial_data),
      .serial_latch_enable(serial_latch_enable[i]), .cap_state(cap[i]),
      .standby_select(stb[i]), .word_seen(seen[i]), .fault_cnt(fcnt[i])
    );
  end
  task stop_test;
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 400);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      error_cnt++;
      stop_test();
    end
  endtask
  // Polls status until frame and settling are both over
  task idle(output int t);
    int s;
    int n;
    logic [31:0] q;
    s = cyc;
    n = 0;
    do
    begin
      bus(1'b0, 4'h8, 32'h0000_0000, q);
      n++;
    end
    while (q !== 32'h0000_0000 && n < 2000);
    t = cyc - s;
    chk("idle", 32'h0000_0000, q);
  endtask
  task t_reset;
    logic [31:0] q;
    logic [3:0] adr [4] = '{4'h0, 4'h8, 4'hc, 4'h2};
    foreach (adr[i])
    begin
      bus(1'b0, adr[i], 32'h0000_0000, q);
      chk("reset read", 32'h0000_0000, q);
    end
  endtask
  task t_fan;
    logic [31:0] q;
    int t;
    logic [4:0] caps [4] = '{5'h00, 5'h0a, 5'h15, 5'h1f};
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 4'h0, i, q);
      bus(1'b1, 4'h4, {24'hff_ffff, 3'h7, caps[i]}, q);
      idle(t);
      chk("word", {3'h1, caps[i]}, seen[i]);
      chk("cap", caps[i], cap[i]);
      chk("standby", 1'b1, stb[i]);
      bus(1'b0, 4'hc, 32'h0000_0000, q);
      chk("last", {24'h00_0000, 3'h1, caps[i]}, q);
      if (i < 3)
        chk("other", 8'h00, seen[i + 1]);
    end
  endtask
  task t_settle;
    logic [31:0] q;
    int t;
    bus(1'b1, 4'h0, 32'h0000_0000, q);
    bus(1'b1, 4'h4, 32'h0000_0005, q);
    idle(t);
    chk("wake", 1'b1, t >= 2800);
    bus(1'b1, 4'h4, 32'h0000_000c, q);
    idle(t);
    chk("switch", 1'b1, t >= 480 && t < 2800);
    chk("cap switch", 5'h0c, cap[0]);
    chk("kept", {3'h1, 5'h0a}, seen[1]);
    bus(1'b1, 4'h4, 32'h0000_0011, q);
    bus(1'b1, 4'h4, 32'h0000_0012, q);
    idle(t);
    chk("back to back", 8'h12, seen[0]);
    chk("active", 1'b0, stb[0]);
  endtask
  initial
  begin
    #2_000_000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_fan();
    t_settle();
    foreach (fcnt[i])
      chk("wire", 32'h0000_0000, fcnt[i]);
    stop_test();
  end
endmodule
`default_nettype wire
